// File: common/pcj_cfg_pkg.sv
// ==========================================================
// configuration header constants for the game-port function
// ==========================================================
package pcj_cfg_pkg;

   // ==========================================================
   // register byte offsets within configuration space
   // ==========================================================
   localparam logic [7:0] OFS_MAKER_IDENTITY = 8'h00;
   localparam logic [7:0] OFS_PART_IDENTITY = 8'h02;
   localparam logic [7:0] OFS_BUS_COMMAND_CONTROL = 8'h04;
   localparam logic [7:0] OFS_BUS_STATUS_FLAGS = 8'h06;
   localparam logic [7:0] OFS_SILICON_REVISION = 8'h08;

   // dword index of each configuration word (offset divided by four)
   localparam logic [5:0] DW_IDENTITY = 6'h00;
   localparam logic [5:0] DW_CMD_STAT = 6'h01;
   localparam logic [5:0] DW_REVISION = 6'h02;

   // ==========================================================
   // command register fields
   // ==========================================================
   localparam int CMD_IO_DECODE_ON = 0;
   localparam int CMD_MEMORY_DECODE_ON = 1;
   localparam int CMD_BUS_MASTER_ALLOW = 2;
   localparam int CMD_SPECIAL_CYCLE_ACCEPT = 3;
   localparam int CMD_WRITE_INVALIDATE_ON = 4;
   localparam int CMD_PALETTE_WATCH_ON = 5;
   localparam int CMD_PARITY_REPORT_ON = 6;
   localparam int CMD_STEPPING = 7;
   localparam int CMD_SYSERR_REPORT_ON = 8;
   localparam int CMD_MASTER_B2B_ALLOW = 9;
   localparam logic [15:0] CMD_RESET = 16'h0000;

   // ==========================================================
   // status register fields
   // ==========================================================
   localparam int STS_DOUBLE_SPEED_CAPABLE = 5;
   localparam int STS_USER_FEATURES_FLAG = 6;
   localparam int STS_TARGET_B2B_CAPABLE = 7;
   localparam int STS_MASTER_PARITY_FLAG = 8;
   localparam int STS_DECODE_SPEED_LO = 9;
   localparam int STS_DECODE_SPEED_HI = 10;
   localparam int STS_TARGET_ABORT_SENT_FLAG = 11;
   localparam int STS_TARGET_ABORT_GOT = 12;
   localparam int STS_MASTER_ABORT_SENT = 13;
   localparam int STS_SYSERR_SENT_FLAG = 14;
   localparam int STS_PARITY_SEEN_FLAG = 15;

   // decode timing encodings
   localparam logic [1:0] DECODE_SPEED_FAST = 2'h0;
   localparam logic [1:0] DECODE_SPEED_MEDIUM = 2'h1;
   localparam logic [1:0] DECODE_SPEED_SLOW = 2'h2;

   localparam logic TARGET_B2B_VALUE = 1'h1;
   localparam logic STICKY_RESET = 1'h0;

   // ==========================================================
   // identity values: arbitrary neutral codes, not a real part
   // ==========================================================
   localparam logic [15:0] MAKER_CODE_DEFAULT = 16'hA5A5;
   localparam logic [15:0] PART_CODE_DEFAULT = 16'h5A01;
   localparam logic [7:0] SILICON_REV_CODE_DEFAULT = 8'h01;

   // read data for unimplemented or out-of-scope words
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

// File: logic/pcj_sticky_flag.sv
`timescale 1ns/100ps
// ==========================================================
// one sticky error flag: hardware sets, a one written clears
// ==========================================================
module pcj_sticky_flag (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic set_evt, // hardware event, one-cycle pulse or level
   input wire logic clr_req, // software wrote a one to this position
   output logic flag_ff // sticky flag value
);

   // ==========================================================
   // flag register
   // ==========================================================
   // set is tested first so an event landing in the clearing cycle is kept
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         flag_ff <= pcj_cfg_pkg::STICKY_RESET;
      end else if (set_evt) begin
         flag_ff <= 1'b1;
      end else if (clr_req) begin
         flag_ff <= 1'b0;
      end
   end

endmodule

// File: logic/pcj_cfg_header.sv
`timescale 1ns/100ps
module pcj_cfg_header #(
   parameter logic [15:0] MAKER_CODE = pcj_cfg_pkg::MAKER_CODE_DEFAULT, // arbitrary value
   parameter logic [15:0] PART_CODE = pcj_cfg_pkg::PART_CODE_DEFAULT, // arbitrary value
   parameter logic [7:0] SILICON_REV_CODE = pcj_cfg_pkg::SILICON_REV_CODE_DEFAULT // arbitrary
) (
   input wire logic ref_clk,
   input wire logic reset,
   // configuration access port from the bus interface
   input wire logic cfg_rd, // configuration read strobe, one cycle
   input wire logic cfg_wr, // configuration write strobe, one cycle
   input wire logic [5:0] cfg_dw_index, // dword index, byte offset bits 7:2
   input wire logic [3:0] cfg_byte_en, // active-high byte enables
   input wire logic [31:0] cfg_wdata, // write data
   output logic [31:0] cfg_rdata_ff, // read data
   output logic cfg_rd_ack_ff, // read data valid, one cycle
   output logic cfg_wr_ack_ff, // write accepted, one cycle
   // error detection from the bus interface
   input wire logic addr_parity_err, // address parity error detected
   input wire logic data_parity_err, // data parity error detected
   input wire logic target_abort_sig, // this function signals target abort
   input wire logic special_cycle, // a special cycle is on the bus
   input wire logic io_addr_match, // I/O address falls in our range
   input wire logic mem_addr_match, // memory address would hit us
   // requests back to the bus interface
   output logic syserr_req_ff, // drive system error this cycle
   output logic parity_req_ff, // drive parity error this cycle
   output logic io_claim_ff, // claim the current I/O cycle
   output logic mem_claim_ff, // never set: memory is not decoded
   output logic bus_req_ff, // never set: no master cycles
   output logic [1:0] decode_speed_ff // select timing for the claim path
);

   // ==========================================================
   // access states
   // ==========================================================
   // one-hot states for the configuration access sequencer
   typedef enum logic [2:0] {
      PCJ_IDLE = 3'b001,
      PCJ_READ = 3'b010,
      PCJ_WRITE = 3'b100
   } pcj_acc_e;

   pcj_acc_e acc_state_ff; // current access phase
   pcj_acc_e nxt_acc_state; // next access phase

   // ==========================================================
   // helper functions
   // ==========================================================
   // true when a write hits the given dword with the given lane enabled
   function automatic logic lane_write(
      input logic wr,
      input logic [5:0] idx,
      input logic [5:0] target,
      input logic [3:0] be,
      input int lane
   );
      logic hit;
      hit = wr && (idx == target) && be[lane];
      return hit;
   endfunction

   // true when software writes a one to a status bit position
   function automatic logic status_clear(
      input logic wr,
      input logic [5:0] idx,
      input logic [3:0] be,
      input logic [31:0] wdata,
      input int bitpos
   );
      logic hit;
      // status sits in the upper half of the command/status dword
      hit = lane_write(wr, idx, pcj_cfg_pkg::DW_CMD_STAT, be, 2 + bitpos / 8)
         && wdata[16 + bitpos];
      return hit;
   endfunction

   // ==========================================================
   // command register storage
   // ==========================================================
   logic io_decode_on_ff; // enables I/O claim
   logic parity_report_on_ff; // enables parity error reporting
   logic syserr_report_on_ff; // enables system error reporting

   // only the three writable bits have storage; the rest stay constant
   // so writes to them are absorbed without any visible effect
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         io_decode_on_ff <= pcj_cfg_pkg::CMD_RESET[pcj_cfg_pkg::CMD_IO_DECODE_ON];
         parity_report_on_ff <= pcj_cfg_pkg::CMD_RESET[pcj_cfg_pkg::CMD_PARITY_REPORT_ON];
         syserr_report_on_ff <= pcj_cfg_pkg::CMD_RESET[pcj_cfg_pkg::CMD_SYSERR_REPORT_ON];
      end else begin
         // low command byte carries bits 0 and 6
         if (lane_write(cfg_wr, cfg_dw_index, pcj_cfg_pkg::DW_CMD_STAT, cfg_byte_en, 0)) begin
            io_decode_on_ff <= cfg_wdata[pcj_cfg_pkg::CMD_IO_DECODE_ON];
            parity_report_on_ff <= cfg_wdata[pcj_cfg_pkg::CMD_PARITY_REPORT_ON];
         end
         // high command byte carries bit 8
         if (lane_write(cfg_wr, cfg_dw_index, pcj_cfg_pkg::DW_CMD_STAT, cfg_byte_en, 1)) begin
            syserr_report_on_ff <= cfg_wdata[pcj_cfg_pkg::CMD_SYSERR_REPORT_ON];
         end
      end
   end

   // ==========================================================
   // error reporting requests
   // ==========================================================
   // address parity errors raise system error only when enabled
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         syserr_req_ff <= 1'b0;
      end else begin
         syserr_req_ff <= addr_parity_err && syserr_report_on_ff;
      end
   end

   // data parity errors raise parity error only when enabled
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         parity_req_ff <= 1'b0;
      end else begin
         parity_req_ff <= data_parity_err && parity_report_on_ff;
      end
   end

   // ==========================================================
   // decode gating
   // ==========================================================
   // I/O claim follows the enable; special cycles never reach the claim
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         io_claim_ff <= 1'b0;
      end else begin
         io_claim_ff <= io_addr_match && io_decode_on_ff && !special_cycle;
      end
   end

   // memory and master paths are tied off inside a flip-flop so the
   // outputs stay registered even though they never change
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mem_claim_ff <= 1'b0;
         bus_req_ff <= 1'b0;
      end else begin
         mem_claim_ff <= mem_addr_match && 1'b0;
         bus_req_ff <= 1'b0;
      end
   end

   // claim timing reported to the bus interface is always medium
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         decode_speed_ff <= pcj_cfg_pkg::DECODE_SPEED_MEDIUM;
      end else begin
         decode_speed_ff <= pcj_cfg_pkg::DECODE_SPEED_MEDIUM;
      end
   end

   // ==========================================================
   // sticky status flags
   // ==========================================================
   logic parity_seen_flag; // any bus parity error seen
   logic syserr_sent_flag; // system error was driven
   logic target_abort_sent_flag; // target abort was signalled

   // parity seen is recorded whatever the response enables say
   pcj_sticky_flag u_parity_seen (
      .ref_clk(ref_clk),
      .reset(reset),
      .set_evt(addr_parity_err || data_parity_err),
      .clr_req(status_clear(cfg_wr, cfg_dw_index, cfg_byte_en, cfg_wdata,
         pcj_cfg_pkg::STS_PARITY_SEEN_FLAG)),
      .flag_ff(parity_seen_flag)
   );

   // set from the registered system error request, so it rises one cycle after the request
   pcj_sticky_flag u_syserr_sent (
      .ref_clk(ref_clk),
      .reset(reset),
      .set_evt(syserr_req_ff),
      .clr_req(status_clear(cfg_wr, cfg_dw_index, cfg_byte_en, cfg_wdata,
         pcj_cfg_pkg::STS_SYSERR_SENT_FLAG)),
      .flag_ff(syserr_sent_flag)
   );

   pcj_sticky_flag u_target_abort_sent (
      .ref_clk(ref_clk),
      .reset(reset),
      .set_evt(target_abort_sig),
      .clr_req(status_clear(cfg_wr, cfg_dw_index, cfg_byte_en, cfg_wdata,
         pcj_cfg_pkg::STS_TARGET_ABORT_SENT_FLAG)),
      .flag_ff(target_abort_sent_flag)
   );

   // ==========================================================
   // register images
   // ==========================================================
   logic [15:0] cmd_image; // command register as read
   logic [15:0] sts_image; // status register as read

   // every bit not stored reads as a fixed zero
   always_comb begin
      cmd_image = 16'h0000;
      cmd_image[pcj_cfg_pkg::CMD_IO_DECODE_ON] = io_decode_on_ff;
      cmd_image[pcj_cfg_pkg::CMD_PARITY_REPORT_ON] = parity_report_on_ff;
      cmd_image[pcj_cfg_pkg::CMD_SYSERR_REPORT_ON] = syserr_report_on_ff;
   end

   // master-only, optional and reserved status bits stay zero
   always_comb begin
      sts_image = 16'h0000;
      sts_image[pcj_cfg_pkg::STS_TARGET_B2B_CAPABLE] = pcj_cfg_pkg::TARGET_B2B_VALUE;
      sts_image[pcj_cfg_pkg::STS_DECODE_SPEED_HI:pcj_cfg_pkg::STS_DECODE_SPEED_LO] =
         pcj_cfg_pkg::DECODE_SPEED_MEDIUM;
      sts_image[pcj_cfg_pkg::STS_TARGET_ABORT_SENT_FLAG] = target_abort_sent_flag;
      sts_image[pcj_cfg_pkg::STS_SYSERR_SENT_FLAG] = syserr_sent_flag;
      sts_image[pcj_cfg_pkg::STS_PARITY_SEEN_FLAG] = parity_seen_flag;
   end

   // ==========================================================
   // access sequencer
   // ==========================================================
   // a read takes priority if both strobes arrive together; the bus
   // side never issues both, so this only fixes a defined outcome
   always_comb begin
      nxt_acc_state = PCJ_IDLE;
      case (acc_state_ff)
         PCJ_IDLE, PCJ_READ, PCJ_WRITE: begin
            if (cfg_rd) begin
               nxt_acc_state = PCJ_READ;
            end else if (cfg_wr) begin
               nxt_acc_state = PCJ_WRITE;
            end else begin
               nxt_acc_state = PCJ_IDLE;
            end
         end
         default: begin
            nxt_acc_state = PCJ_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         acc_state_ff <= PCJ_IDLE;
      end else begin
         acc_state_ff <= nxt_acc_state;
      end
   end

   // ==========================================================
   // read data and acknowledges
   // ==========================================================
   // read data is captured on the strobe edge and held until the next read
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg_rdata_ff <= pcj_cfg_pkg::RDATA_ZERO;
      end else if (cfg_rd) begin
         case (cfg_dw_index)
            pcj_cfg_pkg::DW_IDENTITY: begin
               cfg_rdata_ff <= {PART_CODE, MAKER_CODE};
            end
            pcj_cfg_pkg::DW_CMD_STAT: begin
               cfg_rdata_ff <= {sts_image, cmd_image};
            end
            pcj_cfg_pkg::DW_REVISION: begin
               // class code lives elsewhere; only the revision byte here
               cfg_rdata_ff <= {24'h00_0000, SILICON_REV_CODE};
            end
            default: begin
               cfg_rdata_ff <= pcj_cfg_pkg::RDATA_ZERO;
            end
         endcase
      end
   end

   // acknowledges follow the sequencer, one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg_rd_ack_ff <= 1'b0;
         cfg_wr_ack_ff <= 1'b0;
      end else begin
         cfg_rd_ack_ff <= (nxt_acc_state == PCJ_READ);
         cfg_wr_ack_ff <= (nxt_acc_state == PCJ_WRITE);
      end
   end

endmodule

// File: test/pcj_cfg_header_sva.sv
`timescale 1ns/100ps
// ==========================================================
// port checker for the configuration header
// ==========================================================
module pcj_cfg_header_sva #(
   parameter logic [15:0] MAKER_CODE = 16'h0000, // arbitrary value
   parameter logic [15:0] PART_CODE = 16'h0000, // arbitrary value
   parameter logic [7:0] SILICON_REV_CODE = 8'h00 // arbitrary value
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [5:0] cfg_dw_index,
   input wire logic [31:0] cfg_rdata_ff,
   input wire logic cfg_rd_ack_ff,
   input wire logic cfg_wr_ack_ff,
   input wire logic addr_parity_err,
   input wire logic data_parity_err,
   input wire logic special_cycle,
   input wire logic io_addr_match,
   input wire logic syserr_req_ff,
   input wire logic parity_req_ff,
   input wire logic io_claim_ff,
   input wire logic mem_claim_ff,
   input wire logic bus_req_ff,
   input wire logic [1:0] decode_speed_ff
);
   // ==========================================================
   // one clock domain, so one default clock and reset
   // ==========================================================
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   // a read strobe aimed at one configuration word
   sequence s_rd(logic [5:0] i);
      cfg_rd && cfg_dw_index == i;
   endsequence

   // ==========================================================
   // handshake
   // ==========================================================
   AST_RD_ACK: assert property (cfg_rd |=> cfg_rd_ack_ff)
      else $error("read strobe not acknowledged next cycle");
   AST_WR_ACK: assert property (cfg_wr |=> cfg_wr_ack_ff)
      else $error("write strobe not acknowledged next cycle");

   // ==========================================================
   // fixed read values: only enable bits and sticky flags may vary
   // ==========================================================
   AST_ID_WORD: assert property (s_rd(6'h00) |=> cfg_rdata_ff == {PART_CODE, MAKER_CODE})
      else $error("identity word wrong");
   AST_REV_WORD: assert property (s_rd(6'h02) |=> cfg_rdata_ff == {24'h0, SILICON_REV_CODE})
      else $error("revision word wrong");
   AST_CMD_FIXED: assert property (s_rd(6'h01) |=> (cfg_rdata_ff[15:0] & 16'hFEBE) == 16'h0)
      else $error("read-only command bits not zero");
   AST_STS_FIXED: assert property (s_rd(6'h01) |=> (cfg_rdata_ff[31:16] & 16'h37FF) == 16'h0280)
      else $error("read-only status bits wrong");

   // ==========================================================
   // requests back to the bus need a cause one cycle earlier; memory claim, bus request and decode timing stay fixed
   // ==========================================================
   AST_SERR_CAUSE: assert property (syserr_req_ff |-> $past(addr_parity_err))
      else $error("system error request without address parity error");
   AST_PERR_CAUSE: assert property (!data_parity_err |=> !parity_req_ff)
      else $error("parity error request without data parity error");
   AST_IO_CAUSE: assert property (io_claim_ff |-> $past(io_addr_match && !special_cycle))
      else $error("i/o claim without a plain matching i/o cycle");
   AST_NO_MASTER: assert property (!mem_claim_ff && !bus_req_ff)
      else $error("memory claim or bus request seen");
   AST_SPEED: assert property (decode_speed_ff == 2'h1)
      else $error("decode timing not medium");
endmodule

// File: test/pcj_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// host bridge side: issues configuration reads and writes
// ==========================================================
module pcj_host_model (
   input wire logic ref_clk,
   input wire logic [31:0] cfg_rdata_ff,
   input wire logic cfg_rd_ack_ff,
   output logic cfg_rd,
   output logic cfg_wr,
   output logic [5:0] cfg_dw_index,
   output logic [3:0] cfg_byte_en,
   output logic [31:0] cfg_wdata
);
   // idle bus from time zero
   initial begin
      cfg_rd = 1'b0;
      cfg_wr = 1'b0;
      cfg_dw_index = 6'h3F;
      cfg_byte_en = 4'h0;
      cfg_wdata = 32'h0;
   end

   // one-cycle read; no ack hands back unknowns so the compare fails
   task automatic rd(input logic [5:0] i, output logic [31:0] d);
      @(negedge ref_clk);
      cfg_rd = 1'b1;
      cfg_dw_index = i;
      @(negedge ref_clk);
      cfg_rd = 1'b0;
      cfg_dw_index = ~i; // released lines do not keep the old value
      d = cfg_rd_ack_ff ? cfg_rdata_ff : 32'hX;
   endtask

   // one-cycle write; flags are cleared by ones in the data
   task automatic wr(input logic [5:0] i, input logic [3:0] be, input logic [31:0] w);
      @(negedge ref_clk);
      cfg_wr = 1'b1;
      cfg_dw_index = i;
      cfg_byte_en = be;
      cfg_wdata = w;
      @(negedge ref_clk);
      cfg_wr = 1'b0;
      cfg_dw_index = ~i;
      cfg_byte_en = ~be;
      cfg_wdata = ~w;
   endtask
endmodule

// File: test/pcj_cfg_header_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
// ==========================================================
// bench for the configuration header
// ==========================================================
module pcj_cfg_header_tb;
   localparam logic [15:0] MC = 16'hC3A1; // arbitrary value
   localparam logic [15:0] PC = 16'h0E07; // arbitrary value
   localparam logic [7:0] RC = 8'h4B; // arbitrary value
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] ev = 6'h0; // par_a, par_d, abort, special, io, mem
   logic cfg_rd, cfg_wr, rd_ack, wr_ack, serr, perr, io_c, mem_c, breq;
   logic [5:0] idx;
   logic [3:0] be;
   logic [31:0] wdata, rdata;
   logic [1:0] speed;
   int fails = 0;
   int n_compared = 0;

   // 200 MHz clock
   always #2.5 ref_clk = ~ref_clk;

   pcj_cfg_header #(.MAKER_CODE(MC), .PART_CODE(PC), .SILICON_REV_CODE(RC)) uut (
      .ref_clk, .reset, .cfg_rd, .cfg_wr, .cfg_dw_index(idx), .cfg_byte_en(be),
      .cfg_wdata(wdata), .cfg_rdata_ff(rdata), .cfg_rd_ack_ff(rd_ack),
      .cfg_wr_ack_ff(wr_ack), .addr_parity_err(ev[0]), .data_parity_err(ev[1]),
      .target_abort_sig(ev[2]), .special_cycle(ev[3]), .io_addr_match(ev[4]),
      .mem_addr_match(ev[5]), .syserr_req_ff(serr), .parity_req_ff(perr),
      .io_claim_ff(io_c), .mem_claim_ff(mem_c), .bus_req_ff(breq), .decode_speed_ff(speed));

   pcj_host_model host (
      .ref_clk, .cfg_rdata_ff(rdata), .cfg_rd_ack_ff(rd_ack), .cfg_rd, .cfg_wr,
      .cfg_dw_index(idx), .cfg_byte_en(be), .cfg_wdata(wdata));

   // ==========================================================
   // helpers
   // ==========================================================
   task automatic rdchk(input logic [5:0] i, input logic [31:0] e);
      logic [31:0] d;
      host.rd(i, d);
      `CHK(d, e)
   endtask

   // raise events for one cycle, check the registered requests after
   task automatic evchk(input logic [5:0] v, input logic [4:0] e);
      @(negedge ref_clk);
      ev = v;
      @(negedge ref_clk);
      `CHK({serr, perr, io_c, mem_c, breq}, e)
      ev = 6'h0;
   endtask

   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   // ==========================================================
   initial begin
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      rdchk(6'h00, {PC, MC});
      rdchk(6'h01, 32'h0280_0000);
      rdchk(6'h02, {24'h0, RC});
      rdchk(6'h03, 32'h0);
      `CHK(speed, 2'h1)
      $display("test reset_values done");
      // ones everywhere but the top status byte: only the three enable bits may take them
      host.wr(6'h00, 4'hF, 32'hFFFF_FFFF);
      `CHK(wr_ack, 1'b1)
      host.wr(6'h02, 4'hF, 32'hFFFF_FFFF);
      host.wr(6'h01, 4'h7, 32'h00FF_FFFF);
      rdchk(6'h00, {PC, MC});
      rdchk(6'h02, {24'h0, RC});
      rdchk(6'h01, 32'h0280_0141);
      $display("test read_only_writes done");
      evchk(6'h10, 5'h04);
      evchk(6'h18, 5'h00);
      evchk(6'h20, 5'h00);
      evchk(6'h01, 5'h10);
      rdchk(6'h01, 32'hC280_0141);
      evchk(6'h02, 5'h08);
      host.wr(6'h01, 4'h8, 32'hC000_0000);
      rdchk(6'h01, 32'h0280_0141);
      $display("test error_reporting done");
      // responses off: errors still seen but not reported
      host.wr(6'h01, 4'h3, 32'h0000_0001);
      evchk(6'h01, 5'h00);
      evchk(6'h02, 5'h00);
      rdchk(6'h01, 32'h8280_0001);
      evchk(6'h04, 5'h00);
      rdchk(6'h01, 32'h8A80_0001);
      host.wr(6'h01, 4'hC, 32'h0000_0000);
      rdchk(6'h01, 32'h8A80_0001);
      host.wr(6'h01, 4'h9, 32'h0800_0000);
      rdchk(6'h01, 32'h8280_0000);
      evchk(6'h10, 5'h00);
      $display("test sticky_flags done");
      // reset in mid-run must drop the enables and the sticky flag again
      host.wr(6'h01, 4'h1, 32'h0000_0041);
      @(negedge ref_clk);
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      rdchk(6'h01, 32'h0280_0000);
      $display("test mid_reset done");
      stop_test();
   end

   // the tests take well under 400 cycles
   initial begin
      #20000;
      fails++;
      $display("watchdog expired");
      stop_test();
   end
endmodule

bind pcj_cfg_header pcj_cfg_header_sva #(
   .MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE), .SILICON_REV_CODE(SILICON_REV_CODE)
) chk (
   .ref_clk, .reset, .cfg_rd, .cfg_wr, .cfg_dw_index, .cfg_rdata_ff, .cfg_rd_ack_ff,
   .cfg_wr_ack_ff, .addr_parity_err, .data_parity_err, .special_cycle, .io_addr_match,
   .syserr_req_ff, .parity_req_ff, .io_claim_ff, .mem_claim_ff, .bus_req_ff,
   .decode_speed_ff);
